// ===== pkg/pm_pkg.sv
// Shared constants for the power-management side-band: capability word
// layout, scale codes, power states and the application register map.
// Assumes both ends and the bench import the whole package.
package pm_pkg;
	// Capability word field positions
	localparam int CAP_DATA_LSB = 24;
	localparam int CAP_DATA_MSB = 31;
	localparam int CAP_STATUS_BIT = 15;
	localparam int CAP_SCALE_LSB = 13;
	localparam int CAP_SCALE_MSB = 14;
	localparam int CAP_SEL_LSB = 9;
	localparam int CAP_SEL_MSB = 12;
	localparam int CAP_EN_BIT = 8;
	localparam int CAP_STATE_LSB = 0;
	localparam int CAP_STATE_MSB = 1;
	localparam logic [31:0] CAP_RESET = 32'h0000_0000;
	// Report bus layout: value in [9:2], scale in [1:0]
	localparam int RPT_VAL_LSB = 2;
	localparam int RPT_VAL_MSB = 9;
	localparam int RPT_SCALE_MSB = 1;
	// Scale codes of the report bus and the capability word
	typedef enum logic [1:0] {
		SCALE_UNKNOWN = 2'h0,
		SCALE_TENTH = 2'h1,
		SCALE_HUNDREDTH = 2'h2,
		SCALE_THOUSANDTH = 2'h3
	} scale_t;
	// Power state field encodings
	typedef enum logic [1:0] {
		PS_D0 = 2'h0,
		PS_D1 = 2'h1,
		PS_D2 = 2'h2,
		PS_D3 = 2'h3
	} pstate_t;
	// Data selector codes
	localparam logic [3:0] SEL_PME_STATES = 4'h8;
	// Auxiliary-current bits of the capability structure
	localparam logic [2:0] AUX_CURRENT = 3'h0;
	// Power states in which a wake event may be signalled, bit n = Dn
	localparam logic [7:0] PME_STATE_MASK = 8'h0f;
	// Application register map, byte addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_REPORT = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_MASK = 5'h0c;
	localparam logic [4:0] REG_INFO = 5'h10;
	localparam int CTRL_AUTO_ACK = 0;
	localparam int CTRL_ACK = 1;
	localparam int CTRL_WAKE = 2;
	localparam int ST_TURNOFF = 0;
	localparam int ST_ACKED = 1;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== pkg/pm_link_if.sv
// Side-band wires between the endpoint core and the application logic.
// Assumes both ends run on the same application clock.
`timescale 1ns/10ps
interface pm_link_if;
	logic [9:0] power_report_bus;
	logic aux_supply_present;
	logic turnoff_status_pulse;
	logic turnoff_control_input;
	logic pme_request;
	modport core_end (
		input power_report_bus,
		input aux_supply_present,
		output turnoff_status_pulse,
		input turnoff_control_input,
		input pme_request
	);
	modport app_end (
		output power_report_bus,
		output aux_supply_present,
		input turnoff_status_pulse,
		output turnoff_control_input,
		output pme_request
	);
endinterface

// ===== logic/pm_core_end.sv
// Core end of the power-management side-band: capability word,
// power table, wake signalling and the turn-off handshake.
// Assumes link message strobes are one-cycle pulses on mclk.
//
// Functional notes
// - Scale code 00 unknown, then 0.1/0.01/0.001
// - Watts equal value field times scale factor
// - Application may tie aux indication to zero
// - Capability word fields at fixed bit positions
// - Data field lists wake-capable power states
// - Status shows wake condition regardless of enable
// - Scale field is read-only
// - Selector picks what data and scale show
// - Wake messages only while enable is set
// - State field encodes D0 to D3
// - D3 with aux type is cold, else hot
// - Turn-off message raises turn-off status output
// - Application answers status with control input
// - Turn-off status is one-cycle pulse
// - Report bus used only when aux current zero
`timescale 1ns/10ps
module pm_core_end
	import pm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	pm_link_if.core_end link,
	input wire logic turnoff_msg_rx,
	output logic turnoff_ack_tx,
	output logic pme_msg_tx,
	input wire logic cap_wr,
	input wire logic [31:0] cap_wdata,
	output logic [31:0] cap_rdata,
	output logic d3_cold,
	output logic d3_hot
);

	logic [3:0] selector;
	logic pme_enable;
	pstate_t power_state;
	logic pme_status;
	logic [9:0] power_table [0:3];
	logic awaiting_ack;
	logic turnoff_pulse;
	logic ctrl_seen;
	logic wake_capable;
	logic report_usable;
	logic wake_event;
	logic [7:0] data_field;
	scale_t scale_field;
	logic [31:0] next_cap_rdata;

	// Report bus is only trusted with no aux current claimed
	assign report_usable = (AUX_CURRENT == 3'h0);

	// Wake only counts in a state listed as wake-capable
	assign wake_capable = PME_STATE_MASK[power_state];
	assign wake_event = link.pme_request && wake_capable;

	// Writable fields: selector, enable and state
	// Scale, data and reserved bits are never stored
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			selector <= CAP_RESET[CAP_SEL_MSB:CAP_SEL_LSB];
			pme_enable <= CAP_RESET[CAP_EN_BIT];
			power_state <= PS_D0;
		end
		else if (cap_wr)
		begin
			selector <= cap_wdata[CAP_SEL_MSB:CAP_SEL_LSB];
			pme_enable <= cap_wdata[CAP_EN_BIT];
			power_state <= pstate_t'(
				cap_wdata[CAP_STATE_MSB:CAP_STATE_LSB]);
		end
	end

	// Status is sticky and write-one-to-clear; a new wake wins
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pme_status <= CAP_RESET[CAP_STATUS_BIT];
		else if (wake_event)
			pme_status <= 1'b1;
		else if (cap_wr && cap_wdata[CAP_STATUS_BIT])
			pme_status <= 1'b0;
	end

	// Message only leaves while enabled; status is set either way
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pme_msg_tx <= 1'b0;
		else
			pme_msg_tx <= wake_event && pme_enable;
	end

	// Table holds the last report seen in each power state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 4; i++)
				power_table[i] <= 10'h000;
		end
		else if (report_usable)
			power_table[power_state] <= link.power_report_bus;
	end

	// Selector picks the quantity; scale follows the entry
	always_comb
	begin
		data_field = 8'h00;
		scale_field = SCALE_UNKNOWN;
		if (selector == SEL_PME_STATES)
			data_field = PME_STATE_MASK;
		// Selectors 0 to 3 index the per-state table
		else if (selector < 4'h4)
		begin
			data_field =
				power_table[selector[1:0]][RPT_VAL_MSB:RPT_VAL_LSB];
			scale_field =
				scale_t'(power_table[selector[1:0]][RPT_SCALE_MSB:0]);
		end
	end

	// Assemble the word; reserved ranges stay zero
	always_comb
	begin
		next_cap_rdata = 32'h0000_0000;
		next_cap_rdata[CAP_DATA_MSB:CAP_DATA_LSB] = data_field;
		next_cap_rdata[CAP_STATUS_BIT] = pme_status;
		next_cap_rdata[CAP_SCALE_MSB:CAP_SCALE_LSB] = scale_field;
		next_cap_rdata[CAP_SEL_MSB:CAP_SEL_LSB] = selector;
		next_cap_rdata[CAP_EN_BIT] = pme_enable;
		next_cap_rdata[CAP_STATE_MSB:CAP_STATE_LSB] = power_state;
	end

	// Read data is registered: one cycle behind a write
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cap_rdata <= 32'h0000_0000;
		else
			cap_rdata <= next_cap_rdata;
	end

	// Cold versus hot D3 is decided by the aux type indication
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			d3_cold <= 1'b0;
			d3_hot <= 1'b0;
		end
		else
		begin
			d3_cold <= (power_state == PS_D3) &&
				link.aux_supply_present;
			d3_hot <= (power_state == PS_D3) &&
				!link.aux_supply_present;
		end
	end

	// Turn-off message gives exactly one cycle of status
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			turnoff_pulse <= 1'b0;
		else
			turnoff_pulse <= turnoff_msg_rx;
	end
	// Registered so the app end sees a clean pulse
	assign link.turnoff_status_pulse = turnoff_pulse;

	// Control only counts after status was shown
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			awaiting_ack <= 1'b0;
		else if (turnoff_pulse)
			awaiting_ack <= 1'b1;
		else if (link.turnoff_control_input)
			awaiting_ack <= 1'b0;
	end

	// Edge of control so a held level sends one acknowledge
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ctrl_seen <= 1'b0;
		else
			ctrl_seen <= link.turnoff_control_input;
	end

	// Stray control with no notice awaited is dropped
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			turnoff_ack_tx <= 1'b0;
		else
			turnoff_ack_tx <= awaiting_ack &&
				link.turnoff_control_input && !ctrl_seen;
	end

endmodule

// ===== logic/pm_app_end.sv
// Application end of the side-band: software registers over AXI4-Lite,
// power report drive, turn-off acknowledge and wake requests.
// Assumes the core end shares mclk; no synchronisers needed.
`timescale 1ns/10ps
module pm_app_end
	import pm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	pm_link_if.app_end link,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);

	logic aw_held;
	logic w_held;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic do_write;
	logic auto_ack;
	logic [9:0] report;
	logic [1:0] status;
	logic [1:0] mask;
	logic pending;
	logic ack_req;
	logic wake_req;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Address and data are taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h0000_0000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_REPORT ||
				aw_addr == REG_STATUS || aw_addr == REG_MASK) ?
				AXI_OKAY : AXI_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Byte strobes are ignored: every register fits the low half
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			auto_ack <= 1'b0;
			report <= 10'h000;
			mask <= 2'h0;
			ack_req <= 1'b0;
			wake_req <= 1'b0;
		end
		else
		begin
			ack_req <= do_write && aw_addr == REG_CTRL && w_data[CTRL_ACK];
			wake_req <= do_write && aw_addr == REG_CTRL &&
				w_data[CTRL_WAKE];
			if (do_write && aw_addr == REG_CTRL)
				auto_ack <= w_data[CTRL_AUTO_ACK];
			if (do_write && aw_addr == REG_REPORT)
				report <= w_data[9:0];
			if (do_write && aw_addr == REG_MASK)
				mask <= w_data[1:0];
		end
	end

	// Turn-off stays pending until acknowledged
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pending <= 1'b0;
		else if (link.turnoff_status_pulse)
			pending <= 1'b1;
		else if (auto_ack || ack_req)
			pending <= 1'b0;
	end

	// Control is a one-cycle pulse after status was seen
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			link.turnoff_control_input <= 1'b0;
		else
			link.turnoff_control_input <= pending &&
				(auto_ack || ack_req);
	end

	// Sticky events; a new event wins over a clear
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (!rst_n)
				status[i] <= 1'b0;
			else if (i == ST_TURNOFF ? link.turnoff_status_pulse :
				link.turnoff_control_input)
				status[i] <= 1'b1;
			else if (do_write && aw_addr == REG_STATUS && w_data[i])
				status[i] <= 1'b0;
		end
	end

	assign irq = |(status & mask);

	// Report only driven with no aux current claimed
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			link.power_report_bus <= 10'h000;
			link.pme_request <= 1'b0;
		end
		else
		begin
			link.power_report_bus <= (AUX_CURRENT == 3'h0) ?
				report : 10'h000;
			link.pme_request <= wake_req;
		end
	end

	// Deepest aux-powered state unsupported, so tie low
	assign link.aux_supply_present = 1'b0;

	always_comb
	begin
		next_rresp = AXI_OKAY;
		case (s_axi_araddr)
			REG_CTRL: next_rdata = {31'h0, auto_ack};
			REG_REPORT: next_rdata = {22'h0, report};
			REG_STATUS: next_rdata = {30'h0, status};
			REG_MASK: next_rdata = {30'h0, mask};
			REG_INFO: next_rdata = {31'h0, pending};
			default:
			begin
				next_rdata = 32'h0000_0000;
				next_rresp = AXI_SLVERR;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ===== verif/pm_properties.sv
// Checker for the side-band wires joining the two ends.
// Assumes every wire is sampled on mclk with synchronous rst_n.
`timescale 1ns/10ps
module pm_properties (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [9:0] power_report_bus,
	input wire logic aux_supply_present,
	input wire logic turnoff_status_pulse,
	input wire logic turnoff_control_input,
	input wire logic pme_request
);
	logic armed;
	// Notice seen and not yet answered
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			armed <= 1'b0;
		else if (turnoff_status_pulse)
			armed <= 1'b1;
		else if (turnoff_control_input)
			armed <= 1'b0;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence one_pulse(s);
		s ##1 !s;
	endsequence
	chk_aux_tied_low: assert property (!aux_supply_present)
		else $error("aux indication raised");
	chk_status_single: assert property (turnoff_status_pulse |->
		one_pulse(turnoff_status_pulse))
		else $error("turn-off status longer than one cycle");
	chk_control_single: assert property (turnoff_control_input |->
		one_pulse(turnoff_control_input))
		else $error("turn-off control longer than one cycle");
	chk_wake_single: assert property (pme_request |->
		one_pulse(pme_request))
		else $error("wake request longer than one cycle");
	chk_control_armed: assert property (turnoff_control_input |-> armed)
		else $error("control without a turn-off notice");
	chk_control_apart: assert property (turnoff_status_pulse |->
		!turnoff_control_input)
		else $error("control together with status");
	chk_reset_quiet: assert property ($rose(rst_n) |->
		!(turnoff_status_pulse || turnoff_control_input || pme_request))
		else $error("pulse right after reset");
	chk_report_cleared: assert property ($rose(rst_n) |->
		power_report_bus == 10'h000)
		else $error("report bus not cleared by reset");
endmodule

// ===== verif/pcie_power_mgmt_signals_tb_top.sv
// Bench joining both ends over the side-band interface.
// Assumes registers are reached over AXI4-Lite on mclk.
`timescale 1ns/10ps
module pcie_power_mgmt_signals_tb_top;
	import pm_pkg::*;
	logic mclk = 0, rst_n = 0, msg = 0, cwr = 0;
	logic [31:0] cwd = 0, wd = 0, cap, rd, got;
	logic [4:0] awa = 0, ara = 0;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic awr, wr, bv, arr, rv, irq, ack, pme, cold, hot;
	logic [1:0] br, rr, resp;
	int errors = 0, compares = 0, cyc = 0, acks = 0, pmes = 0;
	pm_link_if link ();
	pm_core_end pm_core_end_i (.mclk(mclk), .rst_n(rst_n),
		.link(link.core_end), .turnoff_msg_rx(msg), .turnoff_ack_tx(ack),
		.pme_msg_tx(pme), .cap_wr(cwr), .cap_wdata(cwd), .cap_rdata(cap),
		.d3_cold(cold), .d3_hot(hot));
	pm_app_end pm_app_end_i (.mclk(mclk), .rst_n(rst_n),
		.link(link.app_end), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .irq(irq));
	pm_properties pm_properties_i (.mclk(mclk), .rst_n(rst_n),
		.power_report_bus(link.power_report_bus),
		.aux_supply_present(link.aux_supply_present),
		.turnoff_status_pulse(link.turnoff_status_pulse),
		.turnoff_control_input(link.turnoff_control_input),
		.pme_request(link.pme_request));
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		acks += ack;
		pmes += pme;
		cyc++;
		// Hang guard
		if (cyc == 20000)
		begin
			errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e)
		begin
			errors++;
			$display("FAIL %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		logic ta, tw;
		@(posedge mclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		ta = 0;
		tw = 0;
		while (!(ta && tw))
		begin
			@(posedge mclk);
			if (!ta && awr)
			begin
				ta = 1;
				awv <= 0;
			end
			if (!tw && wr)
			begin
				tw = 1;
				wv <= 0;
			end
		end
		bre <= 1;
		do @(posedge mclk); while (!bv);
		resp = br;
		bre <= 0;
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
		@(posedge mclk);
		ara <= a;
		arv <= 1;
		do @(posedge mclk); while (!arr);
		arv <= 0;
		rre <= 1;
		do @(posedge mclk); while (!rv);
		d = rd;
		resp = rr;
		rre <= 0;
	endtask
	task automatic cap_put(input logic [31:0] v);
		@(posedge mclk);
		cwr <= 1;
		cwd <= v;
		@(posedge mclk);
		cwr <= 0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic turnoff(input bit auto);
		@(posedge mclk);
		msg <= 1;
		@(posedge mclk);
		msg <= 0;
		#1 chk("status", link.turnoff_status_pulse, 1);
		@(posedge mclk);
		#1 chk("status end", link.turnoff_status_pulse, 0);
		@(posedge mclk);
		@(posedge mclk);
		#1 chk("ack", ack, auto);
	endtask
	task automatic t_reset();
		rd_reg(REG_STATUS, got);
		chk("st0", got, 0);
		chk("cap0", cap, CAP_RESET);
		chk("irq0", irq, 0);
		rd_reg(5'h14, got);
		chk("bad rd resp", resp, AXI_SLVERR);
		chk("bad rd data", got, 0);
		wr_reg(5'h14, 32'h1);
		chk("bad wr", resp, AXI_SLVERR);
	endtask
	task automatic t_fields();
		wr_reg(REG_REPORT, 32'h1ca);
		cap_put(32'h0);
		chk("bus", link.power_report_bus, 10'h1ca);
		chk("value", cap[31:24], 8'h72);
		chk("scale", cap[14:13], SCALE_HUNDREDTH);
		cap_put(32'hff7f_70fc);
		chk("sel8", cap, 32'h0f00_1000);
		for (int s = 0; s < 4; s++)
		begin
			cap_put(s);
			chk("state", cap[1:0], s);
			chk("hot", hot, s == 3);
			chk("cold", cold, 0);
		end
	endtask
	task automatic t_auto();
		wr_reg(REG_MASK, 32'h1);
		wr_reg(REG_CTRL, 32'h1);
		turnoff(1);
		chk("irq", irq, 1);
		wr_reg(REG_STATUS, 32'h3);
		chk("irq clr", irq, 0);
	endtask
	task automatic t_soft();
		int n;
		wr_reg(REG_MASK, 32'h0);
		wr_reg(REG_CTRL, 32'h0);
		n = acks;
		turnoff(0);
		rd_reg(REG_INFO, got);
		chk("pend", got, 1);
		wr_reg(REG_CTRL, 32'h2);
		repeat (4) @(posedge mclk);
		chk("sw ack", acks, n + 1);
		rd_reg(REG_STATUS, got);
		chk("st", got, 3);
		chk("masked", irq, 0);
		wr_reg(REG_MASK, 32'h3);
		chk("unmask", irq, 1);
		wr_reg(REG_STATUS, 32'h3);
		chk("w1c", irq, 0);
	endtask
	task automatic t_wake();
		cap_put(32'h0);
		wr_reg(REG_CTRL, 32'h4);
		repeat (3) @(posedge mclk);
		chk("pme st", cap[15], 1);
		chk("pme off", pmes, 0);
		cap_put(32'h8100);
		chk("st clr", cap[15], 0);
		wr_reg(REG_CTRL, 32'h4);
		repeat (3) @(posedge mclk);
		chk("pme on", pmes, 1);
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_n <= 1;
		t_reset();
		t_fields();
		t_auto();
		t_soft();
		t_wake();
		summarize();
	end
endmodule
